// ### decs_evt_if.sv
`timescale 1ns/1ps
interface decs_evt_if #(parameter int N = 64);
   logic [N-1:0] ev_set;
   logic [N-1:0] enable;
   logic [N-1:0] hw_clr;
   logic [N-1:0] sw_clr;
   logic [N-1:0] miss_clr;
   logic [N-1:0] flag;
   logic [N-1:0] miss;
   modport owner (output ev_set, enable, hw_clr, sw_clr, miss_clr, input flag, miss);
   modport cells (input ev_set, enable, hw_clr, sw_clr, miss_clr, output flag, miss);
endinterface

// ### decs_flag_array.sv
`timescale 1ns/1ps
module decs_flag_array
   import decs_pkg::*;
#(
   parameter int N = NUM_CH
) (
   input wire logic  clk_in,
   input wire logic  rst_n_in,
   decs_evt_if.cells evt_io
);

   logic [N-1:0] flag_q;
   logic [N-1:0] flag_d;
   logic [N-1:0] miss_q;
   logic [N-1:0] miss_d;

   ////////////////////////////////////////////////////////////////////////////
   // Event latches: capture regardless of enable, set beats any clear
   always_comb begin
      flag_d = evt_io.ev_set | (flag_q & ~(evt_io.hw_clr | evt_io.sw_clr));
      // A repeat on an enabled, already latched channel is a lost event
      miss_d = (evt_io.ev_set & evt_io.enable & flag_q)
             | (miss_q & ~evt_io.miss_clr);
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flag_q <= '0;
         miss_q <= '0;
      end else begin
         flag_q <= flag_d;
         miss_q <= miss_d;
      end
   end

   assign evt_io.flag = flag_q;
   assign evt_io.miss = miss_q;

endmodule

// ### decs_pkg.sv
package decs_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Sizes
   localparam int NUM_CH      = 64;
   localparam int WORD_W      = 32;
   localparam int NUM_QUEUE   = 4;
   localparam int NUM_REGION  = 4;
   localparam int QEVT_W      = 8;
   localparam int ADDR_W      = 6;
   localparam int QUEUE_DEPTH = 16;

   ////////////////////////////////////////////////////////////////////////////
   // Register word indices
   localparam logic [5:0] REG_STATUS       = 6'h00;
   localparam logic [5:0] REG_EVT_LOW      = 6'h01;
   localparam logic [5:0] REG_EVT_HIGH     = 6'h02;
   localparam logic [5:0] REG_EN_LOW       = 6'h03;
   localparam logic [5:0] REG_EN_HIGH      = 6'h04;
   localparam logic [5:0] REG_CLR_LOW      = 6'h05;
   localparam logic [5:0] REG_CLR_HIGH     = 6'h06;
   localparam logic [5:0] REG_MISS_LOW     = 6'h07;
   localparam logic [5:0] REG_MISS_HIGH    = 6'h08;
   localparam logic [5:0] REG_MISSCLR_LOW  = 6'h09;
   localparam logic [5:0] REG_MISSCLR_HIGH = 6'h0a;
   localparam logic [5:0] REG_MANUAL_LOW   = 6'h0b;
   localparam logic [5:0] REG_MANUAL_HIGH  = 6'h0c;
   localparam logic [5:0] REG_CHAIN_LOW    = 6'h0d;
   localparam logic [5:0] REG_CHAIN_HIGH   = 6'h0e;
   localparam logic [5:0] REG_REGION_BASE  = 6'h10;

   ////////////////////////////////////////////////////////////////////////////
   // Status word fields
   localparam int ST_QUEUE_LSB = 16;
   localparam int ST_COMP_LSB  = 8;
   localparam int ST_COMP_W    = 6;
   localparam int ST_BUSY      = 4;
   localparam int ST_WSTAT     = 3;
   localparam int ST_REQ       = 2;
   localparam int ST_QEVT      = 1;
   localparam int ST_EVT       = 0;

   localparam logic [5:0]  COMP_MAX     = 6'h3f;
   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
   localparam logic [63:0] CHAN_RESET   = 64'h0000_0000_0000_0000;

   typedef enum logic [0:0] {
      ST_IDLE  = 1'b0,
      ST_OFFER = 1'b1
   } decs_state_type;

endpackage

// ### decs_tc_model.sv
`timescale 1ns/1ps
module decs_tc_model (
   input  wire logic       clk_in,
   input  wire logic       tr_valid_in,
   input  wire logic       stall_in,
   input  wire logic       opt_in,
   input  wire logic [1:0] queue_in,
   output logic            tr_ready_out,
   output logic            tr_cmpl_opt_out,
   output logic [1:0]      tr_queue_out
);
   initial begin
      tr_ready_out = 1'b0;
      tr_cmpl_opt_out = 1'b0;
      tr_queue_out = 2'h0;
   end
   // Qualifiers show inverted values while no offer stands, so stale data never looks valid
   always @(negedge clk_in) begin
      tr_ready_out <= tr_valid_in && !stall_in;
      tr_cmpl_opt_out <= tr_valid_in ? opt_in : !opt_in;
      tr_queue_out <= tr_valid_in ? queue_in : ~queue_in;
   end
endmodule

// ### decs_top.sv
`timescale 1ns/1ps
module decs_top
   import decs_pkg::*;
#(
   parameter int NCH    = NUM_CH,
   parameter int NREG   = NUM_REGION,
   parameter int QDEPTH = QUEUE_DEPTH
) (
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   input  wire logic [NCH-1:0]    event_in,
   input  wire logic [NCH-1:0]    chain_trig_in,
   input  wire logic [QEVT_W-1:0] quick_event_flags_in,
   input  wire logic              reg_rd_in,
   input  wire logic              reg_wr_in,
   input  wire logic [ADDR_W-1:0] reg_addr_in,
   input  wire logic              reg_shadow_in,
   input  wire logic [1:0]        reg_region_in,
   input  wire logic [WORD_W-1:0] reg_wdata_in,
   output logic      [WORD_W-1:0] reg_rdata_out,
   output logic                   tr_valid_out,
   output logic      [5:0]        tr_chan_out,
   input  wire logic              tr_ready_in,
   input  wire logic              tr_cmpl_opt_in,
   input  wire logic [1:0]        tr_queue_in,
   input  wire logic [NUM_QUEUE-1:0] queue_pop_in,
   input  wire logic              tcc_valid_in,
   input  wire logic              wstat_req_active_in,
   input  wire logic              wstat_fifo_pending_in,
   output logic      [WORD_W-1:0] controller_status_word_out
);

   localparam int QCNT_W = $clog2(QDEPTH + 1);

   generate
      if (NCH != 2 * WORD_W || NREG != NUM_REGION || QDEPTH < 1) begin : g_bad_cfg
         $error("decs_top: unsupported channel, region or queue depth setting");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Register port decode
   logic [NCH-1:0] access_mask;
   logic [NCH-1:0] region_en_q [NREG];
   logic [NCH-1:0] region_en_d [NREG];

   // Spread one 32-bit write over the low or high half of a channel set
   function automatic logic [63:0] chan_write(input logic [5:0] low_idx);
      logic [63:0] v;
      v = 64'h0;
      if (reg_wr_in && reg_addr_in == low_idx) begin
         v = {32'h0000_0000, reg_wdata_in};
      end else if (reg_wr_in && reg_addr_in == low_idx + 6'h01) begin
         v = {reg_wdata_in, 32'h0000_0000};
      end
      return v;
   endfunction

   always_comb begin
      access_mask = reg_shadow_in ? region_en_q[reg_region_in] : {NCH{1'b1}};
   end

   logic [NCH-1:0] wr_en_bits;
   logic [NCH-1:0] wr_clr_bits;
   logic [NCH-1:0] wr_missclr_bits;
   logic [NCH-1:0] wr_manual_bits;
   logic           wr_en_hit;

   always_comb begin
      wr_en_hit       = reg_wr_in && (reg_addr_in == REG_EN_LOW || reg_addr_in == REG_EN_HIGH);
      wr_en_bits      = chan_write(REG_EN_LOW) & access_mask;
      wr_clr_bits     = chan_write(REG_CLR_LOW) & access_mask;
      wr_missclr_bits = chan_write(REG_MISSCLR_LOW) & access_mask;
      wr_manual_bits  = chan_write(REG_MANUAL_LOW) & access_mask;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event flags
   decs_evt_if #(.N(NCH)) evt ();

   decs_flag_array #(.N(NCH)) u_flags (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .evt_io   (evt)
   );

   logic [NCH-1:0] enable_q;
   logic [NCH-1:0] enable_d;
   logic [NCH-1:0] manual_q;
   logic [NCH-1:0] manual_d;
   logic [NCH-1:0] chain_q;
   logic [NCH-1:0] chain_d;
   logic [NCH-1:0] svc_clr;
   logic [NCH-1:0] pending;

   assign evt.ev_set   = event_in;
   assign evt.enable   = enable_q;
   assign evt.hw_clr   = svc_clr;
   assign evt.sw_clr   = wr_clr_bits;
   assign evt.miss_clr = wr_missclr_bits;

   always_comb begin
      // Writes to an enable half only touch the bits the region may reach
      enable_d = wr_en_hit ? ((enable_q & ~access_mask) | (wr_en_bits & access_mask)) : enable_q;
      if (wr_en_hit && reg_addr_in == REG_EN_LOW) begin
         enable_d[NCH-1:WORD_W] = enable_q[NCH-1:WORD_W];
      end else if (wr_en_hit) begin
         enable_d[WORD_W-1:0] = enable_q[WORD_W-1:0];
      end
      manual_d = wr_manual_bits | (manual_q & ~svc_clr);
      chain_d  = chain_trig_in | (chain_q & ~svc_clr);
      pending  = (evt.flag & enable_q) | manual_q | chain_q;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         enable_q <= CHAN_RESET;
         manual_q <= CHAN_RESET;
         chain_q  <= CHAN_RESET;
      end else begin
         enable_q <= enable_d;
         manual_q <= manual_d;
         chain_q  <= chain_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Region access enables, writable from the global range only
   generate
      for (genvar r = 0; r < NREG; r++) begin : g_region
         localparam logic [5:0] LOW_IDX = REG_REGION_BASE + 6'(2 * r);
         always_comb begin
            region_en_d[r] = region_en_q[r];
            if (reg_wr_in && !reg_shadow_in && reg_addr_in == LOW_IDX) begin
               region_en_d[r][WORD_W-1:0] = reg_wdata_in;
            end else if (reg_wr_in && !reg_shadow_in && reg_addr_in == LOW_IDX + 6'h01) begin
               region_en_d[r][NCH-1:WORD_W] = reg_wdata_in;
            end
         end
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               region_en_q[r] <= CHAN_RESET;
            end else begin
               region_en_q[r] <= region_en_d[r];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Request submission: lowest pending channel first
   decs_state_type state_q;
   decs_state_type state_d;
   logic [5:0]     chan_q;
   logic [5:0]     chan_d;
   logic [5:0]     comp_q;
   logic [5:0]     comp_d;
   logic           pick_found;
   logic [5:0]     pick_chan;
   logic           accept;

   always_comb begin
      pick_found = 1'b0;
      pick_chan  = 6'h00;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (pending[i]) begin
            pick_found = 1'b1;
            pick_chan  = 6'(i);
         end
      end
   end

   always_comb begin
      state_d = state_q;
      chan_d  = chan_q;
      accept  = 1'b0;
      svc_clr = '0;
      case (state_q)
         ST_IDLE: begin
            // A full completion count holds off every new request
            if (pick_found && comp_q != COMP_MAX) begin
               state_d = ST_OFFER;
               chan_d  = pick_chan;
            end
         end
         ST_OFFER: begin
            if (tr_ready_in) begin
               accept          = 1'b1;
               svc_clr[chan_q] = 1'b1;
               state_d         = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_comb begin
      comp_d = comp_q;
      if (accept && tr_cmpl_opt_in && !tcc_valid_in) begin
         comp_d = comp_q + 6'h01;
      end else if (tcc_valid_in && !(accept && tr_cmpl_opt_in) && comp_q != 6'h00) begin
         comp_d = comp_q - 6'h01;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= ST_IDLE;
         chan_q  <= 6'h00;
         comp_q  <= 6'h00;
      end else begin
         state_q <= state_d;
         chan_q  <= chan_d;
         comp_q  <= comp_d;
      end
   end

   assign tr_valid_out = (state_q == ST_OFFER);
   assign tr_chan_out  = chan_q;

   ////////////////////////////////////////////////////////////////////////////
   // Queue occupancy; counts saturate, the queues themselves bound the fill
   logic [NUM_QUEUE-1:0] queue_busy;

   generate
      for (genvar q = 0; q < NUM_QUEUE; q++) begin : g_queue
         logic [QCNT_W-1:0] cnt_q;
         logic [QCNT_W-1:0] cnt_d;
         logic              push;
         always_comb begin
            push  = accept && tr_queue_in == 2'(q);
            cnt_d = cnt_q;
            if (push && !queue_pop_in[q] && cnt_q != QCNT_W'(QDEPTH)) begin
               cnt_d = cnt_q + QCNT_W'(1);
            end else if (queue_pop_in[q] && !push && cnt_q != '0) begin
               cnt_d = cnt_q - QCNT_W'(1);
            end
         end
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               cnt_q <= '0;
            end else begin
               cnt_q <= cnt_d;
            end
         end
         assign queue_busy[q] = (cnt_q != '0);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Status word
   logic [WORD_W-1:0] status_q;
   logic [WORD_W-1:0] status_d;

   always_comb begin
      status_d = STATUS_RESET;
      status_d[ST_QUEUE_LSB +: NUM_QUEUE] = queue_busy;
      status_d[ST_COMP_LSB +: ST_COMP_W]  = comp_q;
      status_d[ST_WSTAT] = wstat_req_active_in | wstat_fifo_pending_in;
      status_d[ST_REQ]   = (state_q == ST_OFFER);
      status_d[ST_QEVT]  = |quick_event_flags_in;
      status_d[ST_EVT]   = |pending;
      status_d[ST_BUSY]  = |queue_busy | (comp_q != 6'h00)
                         | status_d[ST_WSTAT] | status_d[ST_REQ]
                         | status_d[ST_QEVT] | status_d[ST_EVT];
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         status_q <= STATUS_RESET;
      end else begin
         status_q <= status_d;
      end
   end

   assign controller_status_word_out = status_q;

   ////////////////////////////////////////////////////////////////////////////
   // Register reads; shadow reads see only the region's channels
   logic [WORD_W-1:0] rdata_q;
   logic [WORD_W-1:0] rdata_d;
   logic [NCH-1:0]    rsel;

   always_comb begin
      rsel    = '0;
      rdata_d = rdata_q;
      case (reg_addr_in)
         REG_EVT_LOW, REG_EVT_HIGH:         rsel = evt.flag;
         REG_EN_LOW, REG_EN_HIGH:           rsel = enable_q;
         REG_MISS_LOW, REG_MISS_HIGH:       rsel = evt.miss;
         REG_MANUAL_LOW, REG_MANUAL_HIGH:   rsel = manual_q;
         REG_CHAIN_LOW, REG_CHAIN_HIGH:     rsel = chain_q;
         default:                           rsel = '0;
      endcase
      rsel = rsel & access_mask;
      if (reg_rd_in) begin
         rdata_d = 32'h0000_0000;
         if (reg_addr_in == REG_STATUS) begin
            rdata_d = status_q;
         end else if (reg_addr_in >= REG_REGION_BASE &&
                      reg_addr_in < REG_REGION_BASE + 6'(2 * NREG)) begin
            rdata_d = reg_addr_in[0] ? region_en_q[reg_addr_in[2:1]][NCH-1:WORD_W]
                                     : region_en_q[reg_addr_in[2:1]][WORD_W-1:0];
         end else if (reg_addr_in[0]) begin
            rdata_d = rsel[WORD_W-1:0];
         end else begin
            rdata_d = rsel[NCH-1:WORD_W];
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata_out = rdata_q;

endmodule

// ### decs_top_sva.sv
`timescale 1ns/1ps
module decs_top_sva
   import decs_pkg::*;
(
   input wire logic              clk_in,
   input wire logic              rst_n_in,
   input wire logic [QEVT_W-1:0] quick_event_flags_in,
   input wire logic              tr_valid_out,
   input wire logic [5:0]        tr_chan_out,
   input wire logic              tr_ready_in,
   input wire logic              tr_cmpl_opt_in,
   input wire logic              tcc_valid_in,
   input wire logic              wstat_req_active_in,
   input wire logic              wstat_fifo_pending_in,
   input wire logic [WORD_W-1:0] controller_status_word_out
);
   logic [5:0] cnt;
   logic       acc_opt;
   assign cnt = controller_status_word_out[13:8];
   assign acc_opt = tr_valid_out && tr_ready_in && tr_cmpl_opt_in;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////////////////////////////////////////
   // Status lags its sources by one cycle and the count by two, hence the one- and two-cycle shifts below
   property p_comp_inc;
      (acc_opt && !tcc_valid_in) |=> ##1 (cnt == $past(cnt) + 6'h01);
   endproperty
   a_comp_inc: assert property (p_comp_inc) else $error("count did not rise");
   property p_comp_dec;
      (tcc_valid_in && !acc_opt) |=> (cnt != 6'h00) |-> ##1 (cnt == $past(cnt) - 6'h01);
   endproperty
   a_comp_dec: assert property (p_comp_dec) else $error("count did not fall");
   property p_comp_stall;
      (cnt == COMP_MAX && !$past(tcc_valid_in)) |-> !tr_valid_out;
   endproperty
   a_comp_stall: assert property (p_comp_stall) else $error("offer at full count");
   property p_busy_or;
      controller_status_word_out[ST_BUSY] == (|controller_status_word_out[19:16] ||
         cnt != 6'h00 || |controller_status_word_out[3:0]);
   endproperty
   a_busy_or: assert property (p_busy_or) else $error("busy bit not the OR");
   property p_wstat;
      1'b1 |=> controller_status_word_out[ST_WSTAT] ==
         ($past(wstat_req_active_in) || $past(wstat_fifo_pending_in));
   endproperty
   a_wstat: assert property (p_wstat) else $error("write status bit wrong");
   property p_req_bit;
      1'b1 |=> controller_status_word_out[ST_REQ] == $past(tr_valid_out);
   endproperty
   a_req_bit: assert property (p_req_bit) else $error("request bit wrong");
   property p_quick;
      1'b1 |=> controller_status_word_out[ST_QEVT] == $past(|quick_event_flags_in);
   endproperty
   a_quick: assert property (p_quick) else $error("quick bit wrong");
   property p_reserved;
      controller_status_word_out[31:20] == 12'h000 && controller_status_word_out[15:14] == 2'h0
         && controller_status_word_out[7:5] == 3'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits set");
   property p_offer_hold;
      (tr_valid_out && !tr_ready_in) |=> (tr_valid_out && $stable(tr_chan_out));
   endproperty
   a_offer_hold: assert property (p_offer_hold) else $error("offer dropped");
   property p_offer_gap;
      (tr_valid_out && tr_ready_in) |=> !tr_valid_out;
   endproperty
   a_offer_gap: assert property (p_offer_gap) else $error("offer too soon");
endmodule

// ### decs_top_tb.sv
`timescale 1ns/1ps
module decs_top_tb;
   import decs_pkg::*;
   logic                 clk_in = 1'b0;
   logic                 rst_n_in = 1'b0;
   logic [NUM_CH-1:0]    event_in = 64'h0;
   logic [NUM_CH-1:0]    chain_trig_in = 64'h0;
   logic [QEVT_W-1:0]    quick_event_flags_in = 8'h00;
   logic                 reg_rd_in = 1'b0;
   logic                 reg_wr_in = 1'b0;
   logic [ADDR_W-1:0]    reg_addr_in = 6'h00;
   logic                 reg_shadow_in = 1'b0;
   logic [1:0]           reg_region_in = 2'h0;
   logic [WORD_W-1:0]    reg_wdata_in = 32'h0;
   logic [NUM_QUEUE-1:0] queue_pop_in = 4'h0;
   logic                 tcc_valid_in = 1'b0;
   logic                 wstat_req_active_in = 1'b0;
   logic                 wstat_fifo_pending_in = 1'b0;
   logic                 stall = 1'b0;
   logic                 channel_options = 1'b0;
   logic [1:0]           qsel = 2'h0;
   logic [WORD_W-1:0]    reg_rdata_out;
   logic [WORD_W-1:0]    st;
   logic                 tr_valid_out;
   logic [5:0]           tr_chan_out;
   logic                 tr_ready_in;
   logic                 tr_cmpl_opt_in;
   logic [1:0]           tr_queue_in;
   int                   fail_count = 0;
   int                   comparisons = 0;
   always #5 clk_in = ~clk_in;
   decs_top u_decs_top (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .event_in(event_in), .chain_trig_in(chain_trig_in),
      .quick_event_flags_in(quick_event_flags_in), .reg_rd_in(reg_rd_in), .reg_wr_in(reg_wr_in),
      .reg_addr_in(reg_addr_in), .reg_shadow_in(reg_shadow_in), .reg_region_in(reg_region_in),
      .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .tr_valid_out(tr_valid_out),
      .tr_chan_out(tr_chan_out), .tr_ready_in(tr_ready_in), .tr_cmpl_opt_in(tr_cmpl_opt_in),
      .tr_queue_in(tr_queue_in), .queue_pop_in(queue_pop_in), .tcc_valid_in(tcc_valid_in),
      .wstat_req_active_in(wstat_req_active_in), .wstat_fifo_pending_in(wstat_fifo_pending_in),
      .controller_status_word_out(st));
   decs_tc_model u_decs_tc_model (.clk_in(clk_in), .tr_valid_in(tr_valid_out), .stall_in(stall),
      .opt_in(channel_options), .queue_in(qsel), .tr_ready_out(tr_ready_in),
      .tr_cmpl_opt_out(tr_cmpl_opt_in), .tr_queue_out(tr_queue_in));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   // One strobe cycle; returns two edges later so read data has landed
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                      input logic sh = 1'b0, input logic [1:0] r = 2'h0);
      @(negedge clk_in);
      reg_wr_in = wr;
      reg_rd_in = !wr;
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_shadow_in = sh;
      reg_region_in = r;
      @(negedge clk_in);
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      @(negedge clk_in);
   endtask
   task automatic rd(input string n, input logic [5:0] a, input logic [31:0] exp,
                     input logic sh = 1'b0, input logic [1:0] r = 2'h0);
      bus(1'b0, a, 32'h0, sh, r);
      chk(n, exp, reg_rdata_out);
   endtask
   task automatic pulse(input int ch, input logic chain = 1'b0);
      @(negedge clk_in);
      if (chain) chain_trig_in[ch] = 1'b1;
      else event_in[ch] = 1'b1;
      @(negedge clk_in);
      chain_trig_in = 64'h0;
      event_in = 64'h0;
   endtask
   task automatic wait_acc(input logic [5:0] ch);
      logic       got;
      logic [5:0] seen;
      got = 1'b0;
      seen = 6'h00;
      for (int i = 0; i < 40 && !got; i++) begin
         @(posedge clk_in);
         got = tr_valid_out && tr_ready_in;
         seen = tr_chan_out;
      end
      chk("accept", 32'h1, {31'h0, got});
      chk("channel", {26'h0, ch}, {26'h0, seen});
      repeat (3) @(negedge clk_in);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd("status", REG_STATUS, STATUS_RESET);
      rd("events low", REG_EVT_LOW, 32'h0);
      rd("events high", REG_EVT_HIGH, 32'h0);
      rd("unmapped", 6'h3f, 32'h0);
      $display("t_reset done");
   endtask
   task automatic t_latch;
      pulse(5);
      pulse(40);
      rd("events low", REG_EVT_LOW, 32'h20);
      rd("events high", REG_EVT_HIGH, 32'h100);
      chk("offer", 32'h0, {31'h0, tr_valid_out});
      rd("status", REG_STATUS, 32'h0);
      bus(1'b1, REG_EVT_LOW, 32'hffff_ffff);
      rd("events low", REG_EVT_LOW, 32'h20);
      bus(1'b1, REG_CLR_LOW, 32'hffff_ffdf);
      rd("events low", REG_EVT_LOW, 32'h20);
      bus(1'b1, REG_CLR_LOW, 32'h20);
      bus(1'b1, REG_CLR_HIGH, 32'h100);
      rd("events low", REG_EVT_LOW, 32'h0);
      rd("events high", REG_EVT_HIGH, 32'h0);
      $display("t_latch done");
   endtask
   task automatic t_miss;
      stall = 1'b1;
      bus(1'b1, REG_EN_LOW, 32'h8);
      pulse(3);
      // Status lags the offer by a cycle, and a read returns the registered word
      @(negedge clk_in);
      rd("status", REG_STATUS, 32'h15);
      // Clear and new event hit channel 3 at the same edge
      @(negedge clk_in);
      event_in[3] = 1'b1;
      reg_wr_in = 1'b1;
      reg_addr_in = REG_CLR_LOW;
      reg_wdata_in = 32'h8;
      @(negedge clk_in);
      event_in = 64'h0;
      reg_wr_in = 1'b0;
      rd("events low", REG_EVT_LOW, 32'h8);
      rd("miss low", REG_MISS_LOW, 32'h8);
      bus(1'b1, REG_MISSCLR_LOW, 32'h8);
      rd("miss low", REG_MISS_LOW, 32'h0);
      pulse(3);
      pulse(6);
      pulse(6);
      rd("miss low", REG_MISS_LOW, 32'h8);
      bus(1'b1, REG_CLR_LOW, 32'h40);
      $display("t_miss done");
   endtask
   task automatic t_service;
      channel_options = 1'b1;
      qsel = 2'h0;
      stall = 1'b0;
      wait_acc(6'd3);
      rd("events low", REG_EVT_LOW, 32'h0);
      rd("status", REG_STATUS, 32'h0001_0110);
      @(negedge clk_in);
      queue_pop_in = 4'h1;
      tcc_valid_in = 1'b1;
      @(negedge clk_in);
      queue_pop_in = 4'h0;
      tcc_valid_in = 1'b0;
      rd("status", REG_STATUS, 32'h0);
      channel_options = 1'b0;
      for (int q = 0; q < NUM_QUEUE; q++) begin
         qsel = q[1:0];
         pulse(q + 1, 1'b1);
         wait_acc(6'(q + 1));
         chk("queue bits", 32'h10 | (32'h1 << (16 + q)), st);
         @(negedge clk_in);
         queue_pop_in = 4'h1 << q;
         @(negedge clk_in);
         queue_pop_in = 4'h0;
      end
      bus(1'b1, REG_MANUAL_HIGH, 32'h1);
      wait_acc(6'd32);
      chk("status", 32'h0008_0010, st);
      $display("t_service done");
   endtask
   task automatic t_saturate;
      channel_options = 1'b1;
      bus(1'b1, REG_EN_LOW, 32'h1);
      repeat (63) begin
         pulse(0);
         wait_acc(6'd0);
      end
      chk("status", 32'h0008_3f10, st);
      pulse(0);
      repeat (10) @(negedge clk_in);
      chk("offer", 32'h0, {31'h0, tr_valid_out});
      tcc_valid_in = 1'b1;
      @(negedge clk_in);
      tcc_valid_in = 1'b0;
      wait_acc(6'd0);
      tcc_valid_in = 1'b1;
      repeat (63) @(negedge clk_in);
      tcc_valid_in = 1'b0;
      queue_pop_in = 4'h8;
      // Queue three sits at its saturated depth, so drain it completely
      repeat (QUEUE_DEPTH) @(negedge clk_in);
      queue_pop_in = 4'h0;
      repeat (3) @(negedge clk_in);
      chk("status", 32'h0, st);
      bus(1'b1, REG_EN_LOW, 32'h0);
      $display("t_saturate done");
   endtask
   task automatic t_shadow;
      pulse(7);
      pulse(9);
      bus(1'b1, REG_REGION_BASE + 6'h02, 32'h80);
      rd("shadow r1", REG_EVT_LOW, 32'h80, 1'b1, 2'h1);
      rd("shadow r2", REG_EVT_LOW, 32'h0, 1'b1, 2'h2);
      bus(1'b1, REG_CLR_LOW, 32'h280, 1'b1, 2'h1);
      rd("events low", REG_EVT_LOW, 32'h200);
      bus(1'b1, REG_REGION_BASE + 6'h02, 32'hffff_ffff, 1'b1, 2'h1);
      rd("shadow r1", REG_EVT_LOW, 32'h0, 1'b1, 2'h1);
      bus(1'b1, REG_CLR_LOW, 32'h200);
      $display("t_shadow done");
   endtask
   task automatic t_misc;
      wstat_req_active_in = 1'b1;
      rd("status", REG_STATUS, 32'h18);
      wstat_req_active_in = 1'b0;
      wstat_fifo_pending_in = 1'b1;
      rd("status", REG_STATUS, 32'h18);
      wstat_fifo_pending_in = 1'b0;
      quick_event_flags_in = 8'h40;
      rd("status", REG_STATUS, 32'h12);
      quick_event_flags_in = 8'h00;
      rd("status", REG_STATUS, 32'h0);
      $display("t_misc done");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk_in);
      @(negedge clk_in);
      rst_n_in = 1'b1;
      t_reset();
      t_latch();
      t_miss();
      t_service();
      t_saturate();
      t_shadow();
      t_misc();
      tally_and_finish();
   end
   // The whole run needs about 700 cycles
   initial begin
      #200000;
      fail_count++;
      tally_and_finish();
   end
endmodule
bind decs_top decs_top_sva u_decs_top_sva (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .quick_event_flags_in(quick_event_flags_in), .tr_valid_out(tr_valid_out),
   .tr_chan_out(tr_chan_out), .tr_ready_in(tr_ready_in), .tr_cmpl_opt_in(tr_cmpl_opt_in),
   .tcc_valid_in(tcc_valid_in), .wstat_req_active_in(wstat_req_active_in),
   .wstat_fifo_pending_in(wstat_fifo_pending_in),
   .controller_status_word_out(controller_status_word_out));
